// [rdpm_decoder.sv]
// Purpose: Memory cycle decoder and page mapper for boot ROM, disk ROM, DRAM.
// Assumes: Requests arrive on sys_clk; mem16_pin is an asynchronous pin.
// Notes: Answer for a memory request is registered, one cycle later.
//
// How it works
// - Index 51h bit 0 clear removes boot ROM select at 0A0000h-0AFFFFh.
// - Index 65h nibble 0010 selects boot ROM high 128K, not C/D.
// - Index 65h bit 0 set drops boot ROM top 128K, even with bit 1 set.
// - Index 65h bit 0 reads inverted; the others read as written.
// - Index 65h bit 4 enables shadow; bit 7 allows shadow writes.
// - Index 69h all ones shadows all of 0E0000h-0FFFFFh into DRAM.
// - Shadowing exists only at 0E0000h-0FFFFFh, top of the first megabyte.
// - Separate disk ROM select with 24 address bits, 16-Mbyte space.
// - Index 51h bit 1 picks disk ROM width; 8 bits after reset.
// - Index B8h bits 3-0 size the disk ROM linear range; 0 disables.
// - Linear disk range tops at FEFFFFh; FF0000h upward never disk.
// - Index 6Fh bits 7-4 cap direct DRAM decode below the disk range.
// - Two windows of 16K pages: eight pages and four pages.
// - Eight-page base one of six from 0C0000h; four-page at 0A0000h.
// - Enabled page maps to aligned 16K page in chosen device.
// - Index 6Dh bits 3-0 place the page registers in I/O space.
// - Index 74h bit 1 steers page I/O to eight- or four-page set.
// - Index 65h bit 5 and 74h bit 0 are the window master enables.
// - A page maps only with its own enable and its window's.
// - Disabled pages fall through to shadow or boot ROM decode; otherwise left for the bus.
// - ROM cycles use the plain memory read and write strobes.
// - Boot vector region FF0000h-FFFFFFh always selects boot ROM.
// - Boot ROM is 8 bits unless the 16-bit memory pin is asserted.
`timescale 1ns/1ps
`default_nettype none
module rdpm_decoder (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire rdpm_pkg::rdpm_mem_req_t mem_req,
    input wire logic mem16_pin,
    output rdpm_pkg::rdpm_mem_resp_t mem_resp
);
    import rdpm_pkg::*;

    // Index and config registers
    logic [7:0] cfg_index;
    logic [7:0] rom_config_second;
    logic [7:0] rom_config_first;
    logic [7:0] window_a_addr_extension;
    logic [7:0] shadow_range_enable;
    logic [7:0] page_addr_extension_first;
    logic [7:0] window_base_and_io_loc;
    logic [7:0] page_addr_extension_second;
    logic [7:0] misc_dram_limit;
    logic [7:0] window_a_target_first;
    logic [7:0] window_a_target_second;
    logic [7:0] window_b_target;
    logic [7:0] window_b_control;
    logic [7:0] rom_config_third;

    // Page registers
    logic [7:0] eight_page_window [8];
    logic [7:0] four_page_window [4];

    // Pin synchroniser
    logic mem16_meta;
    logic mem16_sync;

    // I/O decode
    logic cfg_wr;
    logic page_io_hit;
    logic page_io_a;
    logic [2:0] page_slot;
    logic [12:0] page_io_low;
    logic [7:0] next_rdata;

    // Page lookup shared by both windows
    function automatic rdpm_hit_t page_xlat(
        input logic [7:0] page,
        input logic [2:0] upper,
        input logic [1:0] dev,
        input logic [13:0] off,
        input logic gate
    );
        rdpm_hit_t r;
        r.hit = gate & page[B_PAGE_EN];
        r.target = rdpm_target_t'(dev);
        r.addr = {upper, page[6:0], off};
        return r;
    endfunction : page_xlat

    // Two-bit field of a packed per-page byte
    function automatic logic [1:0] pair_of(
        input logic [7:0] r,
        input logic [1:0] i
    );
        return r[{i, 1'b1} -: 2];
    endfunction : pair_of

    // Pin synchroniser for the 16-bit memory select
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mem16_meta <= 1'b0;
            mem16_sync <= 1'b0;
        end else if (ce) begin
            mem16_meta <= mem16_pin;
            mem16_sync <= mem16_meta;
        end
    end

    assign cfg_wr = io_wr && (io_addr == IO_DATA_PORT);
    assign page_io_low = PAGE_IO_BASE + {5'h00, window_base_and_io_loc[3:0],
        4'h0};
    assign page_slot = io_addr[15:13];
    assign page_io_hit = (io_addr[12:0] == page_io_low);
    assign page_io_a = window_b_control[B_WIN_B_STEER_A];

    // Index latch
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cfg_index <= RST_ZERO;
        end else if (ce && io_wr && io_addr == IO_INDEX_PORT) begin
            cfg_index <= io_wdata;
        end
    end

    // Configuration registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rom_config_second <= RST_ROM_CFG2;
            rom_config_first <= RST_ROM_CFG1;
            window_a_addr_extension <= RST_ZERO;
            shadow_range_enable <= RST_ZERO;
            page_addr_extension_first <= RST_ZERO;
            window_base_and_io_loc <= RST_ZERO;
            page_addr_extension_second <= RST_ZERO;
            misc_dram_limit <= RST_ZERO;
            window_a_target_first <= RST_ZERO;
            window_a_target_second <= RST_ZERO;
            window_b_target <= RST_ZERO;
            window_b_control <= RST_ZERO;
            rom_config_third <= RST_ZERO;
        end else if (ce && cfg_wr) begin
            unique case (cfg_index)
                IDX_ROM_CFG2: rom_config_second <= io_wdata;
                IDX_ROM_CFG1: rom_config_first <= io_wdata;
                IDX_WIN_A_EXT: window_a_addr_extension <= io_wdata;
                IDX_SHADOW_EN: shadow_range_enable <= io_wdata;
                IDX_PAGE_EXT1: page_addr_extension_first <= io_wdata;
                IDX_WIN_BASE: window_base_and_io_loc <= io_wdata;
                IDX_PAGE_EXT2: page_addr_extension_second <= io_wdata;
                IDX_MISC_DRAM: misc_dram_limit <= io_wdata;
                IDX_WIN_A_TGT1: window_a_target_first <= io_wdata;
                IDX_WIN_A_TGT2: window_a_target_second <= io_wdata;
                IDX_WIN_B_TGT: window_b_target <= io_wdata;
                IDX_WIN_B_CTL: window_b_control <= io_wdata;
                IDX_ROM_CFG3: rom_config_third <= io_wdata;
                // Unknown index ignored
                default: ;
            endcase
        end
    end

    // Page registers behind their own I/O addresses
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                eight_page_window[i] <= RST_ZERO;
            end
            for (int i = 0; i < 4; i++) begin
                four_page_window[i] <= RST_ZERO;
            end
        end else if (ce && io_wr && page_io_hit) begin
            if (page_io_a) begin
                eight_page_window[page_slot] <= io_wdata;
            end else if (!page_slot[2]) begin
                // Slots 4-7 ignored
                four_page_window[page_slot[1:0]] <= io_wdata;
            end
        end
    end

    // Read multiplexer
    always_comb begin
        next_rdata = RST_ZERO;
        if (io_addr == IO_INDEX_PORT) begin
            next_rdata = cfg_index;
        end else if (io_addr == IO_DATA_PORT) begin
            unique case (cfg_index)
                IDX_ROM_CFG2: next_rdata = rom_config_second;
                IDX_ROM_CFG1: next_rdata = rom_config_first
                    ^ (8'h01 << B_CFG1_TOP_OFF);
                IDX_WIN_A_EXT: next_rdata = window_a_addr_extension;
                IDX_SHADOW_EN: next_rdata = shadow_range_enable;
                IDX_PAGE_EXT1: next_rdata = page_addr_extension_first;
                IDX_WIN_BASE: next_rdata = window_base_and_io_loc;
                IDX_PAGE_EXT2: next_rdata = page_addr_extension_second;
                IDX_MISC_DRAM: next_rdata = misc_dram_limit;
                IDX_WIN_A_TGT1: next_rdata = window_a_target_first;
                IDX_WIN_A_TGT2: next_rdata = window_a_target_second;
                IDX_WIN_B_TGT: next_rdata = window_b_target;
                IDX_WIN_B_CTL: next_rdata = window_b_control;
                IDX_ROM_CFG3: next_rdata = rom_config_third;
                // Unknown index reads 0
                default: next_rdata = RST_ZERO;
            endcase
        end else if (page_io_hit) begin
            if (page_io_a) begin
                next_rdata = eight_page_window[page_slot];
            end else if (!page_slot[2]) begin
                next_rdata = four_page_window[page_slot[1:0]];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            io_rdata <= RST_ZERO;
        end else if (ce && io_rd) begin
            io_rdata <= next_rdata;
        end
    end

    // Memory decode
    logic [23:0] ma;
    logic [7:0] seg;

    // Eight-page window
    logic [2:0] a_sel;
    logic [23:0] a_base;
    logic [23:0] a_off;
    logic a_in;
    logic [2:0] a_idx;
    logic [1:0] b_idx;
    logic [2:0] a_upper;
    logic [1:0] a_dev;

    // Window lookups
    rdpm_hit_t a_hit;
    rdpm_hit_t b_hit;

    // Flat decode
    logic boot_range;
    logic shadow_range;
    logic disk_linear;
    logic dram_direct;
    rdpm_target_t next_target;
    logic [23:0] next_addr;
    logic next_block;

    assign ma = mem_req.addr;
    assign seg = ma[23:16];
    assign a_sel = window_base_and_io_loc[6:4];
    assign a_base = WIN_A_FIRST + WIN_A_STEP * {21'h0, a_sel};
    assign a_off = ma - a_base;
    assign a_in = (a_sel < WIN_A_POSITIONS) && (ma >= a_base)
        && (a_off[23:17] == 7'h00);
    assign a_idx = a_off[16:14];
    assign b_idx = ma[15:14];

    // Per-page A23-A21, device
    always_comb begin
        a_upper[2] = page_addr_extension_first[a_idx];
        if (!a_idx[2]) begin
            a_upper[1:0] = pair_of(page_addr_extension_second, a_idx[1:0]);
            a_dev = pair_of(window_a_target_first, a_idx[1:0]);
        end else begin
            a_upper[1:0] = pair_of(window_a_addr_extension, a_idx[1:0]);
            a_dev = pair_of(window_a_target_second, a_idx[1:0]);
        end
    end

    assign a_hit = page_xlat(eight_page_window[a_idx], a_upper, a_dev,
        ma[13:0], a_in && rom_config_first[B_CFG1_WIN_A_EN]);
    assign b_hit = page_xlat(four_page_window[b_idx], 3'(window_b_control[4:2]),
        pair_of(window_b_target, b_idx), ma[13:0],
        seg == SEG_WIN_B && window_b_control[B_WIN_B_EN]);

    // Boot ROM ranges in the first megabyte
    always_comb begin
        boot_range = 1'b0;
        if (seg == SEG_WIN_B) begin
            boot_range = rom_config_second[B_CFG2_BOOT_A];
        end else if (seg[7:1] == SEG_TOP_PAIR) begin
            boot_range = rom_config_first[B_CFG1_TOP_ON]
                && !rom_config_first[B_CFG1_TOP_OFF];
        end else if (seg == SEG_C) begin
            boot_range = rom_config_first[B_CFG1_C_ON];
        end else if (seg == SEG_D) begin
            boot_range = rom_config_first[B_CFG1_D_ON];
        end
    end

    // Top two segments only
    assign shadow_range = rom_config_first[B_CFG1_SHADOW]
        && seg[7:1] == SEG_TOP_PAIR && shadow_range_enable[ma[16:14]];

    // Grows down from FEFFFFh
    assign disk_linear = rom_config_third[3:0] != 4'h0
        && seg != SEG_BOOT_VECTOR
        && {1'b0, ma[23:20]} >= MEG_COUNT - {1'b0, rom_config_third[3:0]};

    // Limit above first Mbyte
    assign dram_direct = (ma[23:20] == LOW_MEG_TOP) ? (ma[19:0] < CONV_RAM_END)
        : (misc_dram_limit[7:4] == 4'h0 || ma[23:20] < misc_dram_limit[7:4]);

    always_comb begin
        next_target = TGT_NONE;
        next_addr = ma;
        next_block = 1'b0;
        // First match wins
        if (seg == SEG_BOOT_VECTOR) begin
            next_target = TGT_BOOT;
        end else if (b_hit.hit) begin
            next_target = b_hit.target;
            next_addr = b_hit.addr;
        end else if (a_hit.hit) begin
            next_target = a_hit.target;
            next_addr = a_hit.addr;
        end else if (shadow_range) begin
            if (mem_req.wr && !rom_config_first[B_CFG1_SHADOW_WR]) begin
                // No select, no strobe
                next_block = 1'b1;
            end else begin
                next_target = TGT_DRAM;
            end
        end else if (ma[23:20] == LOW_MEG_TOP && ma[19:0] >= CONV_RAM_END) begin
            // Never DRAM here
            if (boot_range) begin
                next_target = TGT_BOOT;
            end
        end else if (disk_linear) begin
            next_target = TGT_DISK;
        end else if (dram_direct) begin
            next_target = TGT_DRAM;
        end
    end

    // Registered answer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mem_resp <= '0;
        end else if (ce) begin
            if (mem_req.rd || mem_req.wr) begin
                mem_resp.boot_rom_select <= next_target == TGT_BOOT;
                mem_resp.disk_image_rom_select <= next_target == TGT_DISK;
                mem_resp.dram_select <= next_target == TGT_DRAM;
                mem_resp.xlat_addr <= next_addr;
                mem_resp.wide16 <= (next_target == TGT_DISK)
                    ? rom_config_second[B_CFG2_DISK16]
                    : (next_target == TGT_BOOT) ? mem16_sync : 1'b0;
                mem_resp.write_protect_hit <= next_block;
                mem_resp.memr_strobe <= mem_req.rd;
                mem_resp.memw_strobe <= mem_req.wr && !next_block;
            end else begin
                mem_resp <= '0;
            end
        end
    end
endmodule : rdpm_decoder
`default_nettype wire

// [rdpm_pkg.sv]
// Purpose: Shared constants and types for the ROM decode and page mapper.
// Assumes: 24-bit system memory addresses, 16-bit I/O addresses.
// Notes: Config registers sit behind an index/data port pair.
package rdpm_pkg;
    // Index/data port pair
    localparam logic [15:0] IO_INDEX_PORT = 16'h0022;
    localparam logic [15:0] IO_DATA_PORT = 16'h0023;
    // Config register indexes
    localparam logic [7:0] IDX_ROM_CFG2 = 8'h51;
    localparam logic [7:0] IDX_ROM_CFG1 = 8'h65;
    localparam logic [7:0] IDX_WIN_A_EXT = 8'h67;
    localparam logic [7:0] IDX_SHADOW_EN = 8'h69;
    localparam logic [7:0] IDX_PAGE_EXT1 = 8'h6c;
    localparam logic [7:0] IDX_WIN_BASE = 8'h6d;
    localparam logic [7:0] IDX_PAGE_EXT2 = 8'h6e;
    localparam logic [7:0] IDX_MISC_DRAM = 8'h6f;
    localparam logic [7:0] IDX_WIN_A_TGT1 = 8'h71;
    localparam logic [7:0] IDX_WIN_A_TGT2 = 8'h72;
    localparam logic [7:0] IDX_WIN_B_TGT = 8'h73;
    localparam logic [7:0] IDX_WIN_B_CTL = 8'h74;
    localparam logic [7:0] IDX_ROM_CFG3 = 8'hb8;
    // Reset values
    localparam logic [7:0] RST_ROM_CFG1 = 8'h02;
    localparam logic [7:0] RST_ROM_CFG2 = 8'h01;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Field positions
    localparam int B_CFG2_BOOT_A = 0;
    localparam int B_CFG2_DISK16 = 1;
    localparam int B_CFG1_TOP_OFF = 0;
    localparam int B_CFG1_TOP_ON = 1;
    localparam int B_CFG1_C_ON = 2;
    localparam int B_CFG1_D_ON = 3;
    localparam int B_CFG1_SHADOW = 4;
    localparam int B_CFG1_WIN_A_EN = 5;
    localparam int B_CFG1_SHADOW_WR = 7;
    localparam int B_WIN_B_EN = 0;
    localparam int B_WIN_B_STEER_A = 1;
    localparam int B_PAGE_EN = 7;
    // Page register I/O placement
    localparam logic [12:0] PAGE_IO_BASE = 13'h0208;
    // Memory map
    localparam logic [7:0] SEG_BOOT_VECTOR = 8'hff;
    localparam logic [7:0] SEG_WIN_B = 8'h0a;
    localparam logic [7:0] SEG_C = 8'h0c;
    localparam logic [7:0] SEG_D = 8'h0d;
    localparam logic [6:0] SEG_TOP_PAIR = 7'h07;
    localparam logic [23:0] WIN_A_FIRST = 24'h0c0000;
    localparam logic [23:0] WIN_A_STEP = 24'h004000;
    localparam logic [2:0] WIN_A_POSITIONS = 3'd6;
    localparam logic [3:0] LOW_MEG_TOP = 4'h0;
    localparam logic [19:0] CONV_RAM_END = 20'ha0000;
    localparam logic [4:0] MEG_COUNT = 5'h10;

    typedef enum logic [1:0] {
        TGT_DRAM,
        TGT_BOOT,
        TGT_DISK,
        TGT_NONE
    } rdpm_target_t;

    typedef struct packed {
        logic [23:0] addr;
        logic rd;
        logic wr;
    } rdpm_mem_req_t;

    typedef struct packed {
        logic boot_rom_select;
        logic disk_image_rom_select;
        logic dram_select;
        logic [23:0] xlat_addr;
        logic wide16;
        logic write_protect_hit;
        logic memr_strobe;
        logic memw_strobe;
    } rdpm_mem_resp_t;

    typedef struct packed {
        logic hit;
        rdpm_target_t target;
        logic [23:0] addr;
    } rdpm_hit_t;
endpackage : rdpm_pkg

// [rdpm_decoder_chk.sv]
// Purpose: Port-level checks for the ROM decode and page mapper.
// Assumes: one clock domain.
// Notes: Bound to rdpm_decoder after the module.
`timescale 1ns/1ps
`default_nettype none
module rdpm_decoder_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire rdpm_pkg::rdpm_mem_req_t mem_req,
    input wire logic mem16_pin,
    input wire rdpm_pkg::rdpm_mem_resp_t mem_resp
);
    import rdpm_pkg::*;
    logic req;
    logic pin_q;
    logic [2:0] pin_age;
    assign req = ce && (mem_req.rd || mem_req.wr);
    // Cycles the 16-bit pin has stood still
    always_ff @(posedge sys_clk) begin
        pin_q <= mem16_pin;
        if (!rst_n || pin_q != mem16_pin) begin
            pin_age <= 3'h0;
        end else if (pin_age != 3'h7) begin
            pin_age <= pin_age + 3'h1;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    AST_BOOT_VECTOR: assert property (req && mem_req.addr[23:16] == 8'hff
        |=> mem_resp.boot_rom_select && mem_resp.xlat_addr == $past(mem_req.addr))
        else $error("boot vector not on boot ROM");
    AST_DISK_NOT_TOP: assert property (mem_resp.disk_image_rom_select
        |-> $past(mem_req.addr[23:16]) != 8'hff)
        else $error("disk ROM selected in top segment");
    AST_ONE_SELECT: assert property ($onehot0({mem_resp.boot_rom_select,
        mem_resp.disk_image_rom_select, mem_resp.dram_select}))
        else $error("more than one select");
    AST_IDLE_QUIET: assert property (ce && !mem_req.rd && !mem_req.wr
        |=> mem_resp == '0)
        else $error("response without request");
    AST_ROM_STROBE: assert property (mem_resp.boot_rom_select
        || mem_resp.disk_image_rom_select |-> mem_resp.memr_strobe ==
        $past(mem_req.rd) && mem_resp.memw_strobe == $past(mem_req.wr))
        else $error("ROM cycle strobe wrong");
    AST_PROTECT: assert property (mem_resp.write_protect_hit
        |-> !mem_resp.memw_strobe && !mem_resp.dram_select && $past(mem_req.wr))
        else $error("protected write leaked");
    AST_LOW_DRAM: assert property (req && mem_req.addr < 24'h0a0000
        |=> mem_resp.dram_select && mem_resp.xlat_addr == $past(mem_req.addr))
        else $error("low memory not on DRAM");
    AST_RDATA_HOLD: assert property (!(ce && io_rd) |=> $stable(io_rdata))
        else $error("read data moved without read");
    AST_BOOT_WIDTH: assert property (mem_resp.boot_rom_select && pin_age >= 3'h4
        |-> mem_resp.wide16 == $past(mem16_pin))
        else $error("boot width not from pin");
    COV_BOOT: cover property (mem_resp.boot_rom_select && mem_resp.wide16);
    COV_DISK: cover property (mem_resp.disk_image_rom_select);
    COV_WP: cover property (mem_resp.write_protect_hit);
    COV_PAGE: cover property (mem_resp.dram_select
        && mem_resp.xlat_addr != $past(mem_req.addr));
endmodule : rdpm_decoder_chk
bind rdpm_decoder rdpm_decoder_chk chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .ce(ce), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_req(mem_req),
    .mem16_pin(mem16_pin), .mem_resp(mem_resp));
`default_nettype wire

// [rdpm_far_side.sv]
// Purpose: Far-side memory devices seen by the decoder.
// Assumes: Boot ROM width strap steered by the bench.
// Notes: Flags boot and disk ROM selects in one cycle.
`timescale 1ns/1ps
`default_nettype none
module rdpm_far_side (
    input wire logic sys_clk,
    input wire logic wide_rom,
    input wire rdpm_pkg::rdpm_mem_resp_t mem_resp,
    output logic mem16_pin,
    output logic clash
);
    import rdpm_pkg::*;
    assign mem16_pin = wide_rom;
    // Both ROMs driving the data bus at once
    always @(posedge sys_clk) begin
        clash <= (clash === 1'b1) || (mem_resp.boot_rom_select
            && mem_resp.disk_image_rom_select);
    end
endmodule : rdpm_far_side
`default_nettype wire

// [rom_decode_and_page_mapper_test.sv]
// Purpose: Self-checking bench for the ROM decode and page mapper.
// Assumes: Inputs change on the falling edge; answers one cycle later.
// Notes: Expected results queued by the driver, checked by a monitor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module rom_decode_and_page_mapper_test;
    import rdpm_pkg::*;
    typedef struct {bit io; logic [2:0] sel; bit cx; logic [23:0] xa;
        bit cw; logic w; logic [7:0] rd;} rdpm_note_t;
    localparam logic [2:0] SB = 3'b100;
    localparam logic [2:0] SD = 3'b010;
    localparam logic [2:0] SR = 3'b001;
    localparam logic [2:0] SN = 3'b000;
    logic sys_clk = 1'b0;
    logic rst_n, ce, io_wr, io_rd, mem16_pin, wide_rom, clash, pend;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata;
    logic [1:0] wchk = 2'b00;
    logic [23:0] a;
    logic [31:0] seed = 32'd67767;
    rdpm_mem_req_t mem_req;
    rdpm_mem_resp_t mem_resp;
    rdpm_note_t notes[$];
    rdpm_note_t n;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] ridx [6] = '{8'h51, 8'h65, 8'h69, 8'h6d, 8'hb8, 8'h40};
    logic [7:0] rval [6] = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    always #5 sys_clk = ~sys_clk;
    rdpm_decoder dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .mem_req(mem_req), .mem16_pin(mem16_pin),
        .mem_resp(mem_resp));
    rdpm_far_side far_u (.sys_clk(sys_clk), .wide_rom(wide_rom),
        .mem_resp(mem_resp), .mem16_pin(mem16_pin), .clash(clash));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    task automatic close_out();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic io_put(input logic [15:0] ad, input logic [7:0] d);
        @(negedge sys_clk);
        io_addr = ad;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge sys_clk);
        io_wr = 1'b0;
    endtask : io_put
    task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
        io_put(IO_INDEX_PORT, idx);
        io_put(IO_DATA_PORT, d);
    endtask : cfg
    task automatic io_get(input logic [15:0] ad, input logic [7:0] e);
        rdpm_note_t t;
        t = '{io: 1'b1, sel: SN, cx: 1'b0, xa: '0, cw: 1'b0, w: 1'b0, rd: e};
        @(negedge sys_clk);
        io_addr = ad;
        io_rd = 1'b1;
        notes.push_back(t);
        @(negedge sys_clk);
        io_rd = 1'b0;
    endtask : io_get
    task automatic mem(input logic [23:0] ad, input bit w, input logic [2:0] s,
                       input bit cx, input logic [23:0] xa);
        rdpm_note_t t;
        t = '{io: 1'b0, sel: s, cx: cx, xa: xa, cw: wchk[1], w: wchk[0],
              rd: 8'h00};
        @(negedge sys_clk);
        mem_req = '{addr: ad, rd: !w, wr: w};
        notes.push_back(t);
        @(negedge sys_clk);
        mem_req = '0;
    endtask : mem
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        pend <= rst_n && (io_rd || mem_req.rd || mem_req.wr);
        if (cycles >= 20000) begin
            failures++;
            $display("[FAIL] %0t timeout", $time);
            close_out();
        end
    end
    always @(negedge sys_clk) begin
        if (pend === 1'b1 && notes.size() == 0) begin
            failures++;
            $display("[FAIL] %0t no note", $time);
        end else if (pend === 1'b1) begin
            n = notes.pop_front();
            if (n.io) `CHK(io_rdata, n.rd)
            else begin
                `CHK({mem_resp.boot_rom_select, mem_resp.disk_image_rom_select,
                      mem_resp.dram_select}, n.sel)
                if (n.cx) `CHK(mem_resp.xlat_addr, n.xa)
                if (n.cw) `CHK(mem_resp.wide16, n.w)
            end
        end
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        {io_addr, io_wr, io_rd, io_wdata, wide_rom} = '0;
        mem_req = '0;
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        foreach (ridx[i]) begin
            io_put(IO_INDEX_PORT, ridx[i]);
            io_get(IO_DATA_PORT, rval[i]);
        end
        mem(24'h0a1000, 0, SB, 0, 0);
        mem(24'h0e0000, 0, SB, 0, 0);
        mem(24'h0c0000, 0, SN, 0, 0);
        mem(24'hff1234, 1, SB, 1, 24'hff1234);
        cfg(IDX_ROM_CFG2, 8'h00);
        mem(24'h0a1000, 0, SN, 0, 0);
        cfg(IDX_ROM_CFG1, 8'h0e);
        mem(24'h0c4000, 0, SB, 0, 0);
        cfg(IDX_ROM_CFG1, 8'h02);
        mem(24'h0dffff, 0, SN, 0, 0);
        mem(24'h0fffff, 0, SB, 0, 0);
        cfg(IDX_ROM_CFG1, 8'h03);
        mem(24'h0e0000, 0, SN, 0, 0);
        io_get(IO_DATA_PORT, 8'h02);
        cfg(IDX_ROM_CFG1, 8'h91);
        cfg(IDX_SHADOW_EN, 8'hff);
        mem(24'h0e0000, 0, SR, 1, 24'h0e0000);
        mem(24'h0ffff0, 1, SR, 1, 24'h0ffff0);
        mem(24'h0c0000, 0, SN, 0, 0);
        cfg(IDX_ROM_CFG1, 8'h11);
        mem(24'h0e4000, 1, SN, 0, 0);
        mem(24'h0e4000, 0, SR, 0, 0);
        cfg(IDX_SHADOW_EN, 8'h01);
        mem(24'h0e4000, 0, SN, 0, 0);
        mem(24'h0e3fff, 0, SR, 0, 0);
        cfg(IDX_MISC_DRAM, 8'hf0);
        cfg(IDX_ROM_CFG3, 8'h01);
        wchk = 2'b10;
        mem(24'hf00000, 0, SD, 0, 0);
        mem(24'hfeffff, 0, SD, 0, 0);
        cfg(IDX_ROM_CFG2, 8'h02);
        wchk = 2'b11;
        mem(24'hf80000, 0, SD, 0, 0);
        wchk = 2'b00;
        mem(24'hff0000, 0, SB, 0, 0);
        mem(24'hefffff, 0, SR, 0, 0);
        cfg(IDX_MISC_DRAM, 8'h10);
        cfg(IDX_ROM_CFG3, 8'h0f);
        mem(24'h100000, 0, SD, 0, 0);
        cfg(IDX_ROM_CFG3, 8'h00);
        mem(24'h100000, 0, SN, 0, 0);
        cfg(IDX_WIN_B_CTL, 8'h02);
        cfg(IDX_WIN_BASE, 8'h40);
        cfg(IDX_WIN_A_TGT1, 8'h08);
        cfg(IDX_WIN_A_TGT2, 8'h01);
        io_put(16'h0208, 8'h85);
        io_put(16'h2208, 8'h83);
        io_put(16'h4208, 8'h07);
        io_put(16'h8208, 8'h81);
        io_get(16'h2208, 8'h83);
        mem(24'h0d0010, 0, SN, 0, 0);
        cfg(IDX_ROM_CFG1, 8'h20);
        mem(24'h0d0010, 0, SR, 1, 24'h014010);
        mem(24'h0d4020, 0, SD, 1, 24'h00c020);
        mem(24'h0d8000, 0, SN, 0, 0);
        mem(24'h0e0000, 0, SB, 1, 24'h004000);
        cfg(IDX_WIN_BASE, 8'h01);
        mem(24'h0c0010, 0, SR, 1, 24'h014010);
        cfg(IDX_WIN_BASE, 8'h51);
        mem(24'h0d4010, 0, SR, 1, 24'h014010);
        cfg(IDX_WIN_BASE, 8'h61);
        mem(24'h0d8010, 0, SN, 0, 0);
        cfg(IDX_WIN_B_CTL, 8'h09);
        cfg(IDX_WIN_B_TGT, 8'h40);
        io_put(16'h6218, 8'h80);
        io_get(16'h0218, 8'h00);
        io_get(16'h6218, 8'h80);
        io_put(16'h8218, 8'h80);
        io_get(16'h8218, 8'h00);
        ce = 1'b0;
        io_put(IO_INDEX_PORT, IDX_ROM_CFG3);
        ce = 1'b1;
        io_get(IO_DATA_PORT, 8'h40);
        mem(24'h0ac123, 0, SB, 1, 24'h400123);
        mem(24'h0a0000, 0, SN, 0, 0);
        wide_rom = 1'b1;
        repeat (5) @(negedge sys_clk);
        wchk = 2'b11;
        mem(24'hff0000, 0, SB, 0, 0);
        wide_rom = 1'b0;
        repeat (5) @(negedge sys_clk);
        wchk = 2'b10;
        mem(24'hff0000, 0, SB, 0, 0);
        wchk = 2'b00;
        repeat (8) begin
            seed = xs(seed);
            a = {5'h00, seed[18:0]};
            mem(a, seed[20], SR, 1, a);
        end
        repeat (3) @(negedge sys_clk);
        `CHK(clash, 1'b0)
        `CHK(notes.size(), 0)
        close_out();
    end
endmodule : rom_decode_and_page_mapper_test
`default_nettype wire
